// file: rtl/psd_scan_ctrl.sv
// Control logic of a triple panel scan driver
`timescale 1ns/1ns
// Notes on behaviour
// - Below lockout, gate clock and frame outputs high impedance
// - Frame output follows frame and first line
// - Frame high: true follows line, inverse opposite
// - Frame low, line low: float, share
// - Frame low, line rising edge toggles outputs
// - Frame low, line held high: hold state
// - Share state links outputs to share inputs
// - Enable low above lockout: outputs low rail
// - Enable rising after lockout starts the delay
// - Enable already high: delay starts at threshold
// - Delay ends when node reaches reference
// - Discharge control low closes rail switch
module psd_scan_ctrl
  import psd_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic SUPPLY_LOCKOUT_OK,
  input wire logic EN,
  input wire logic FRAME_START_IN,
  input wire logic [NUM_CH-1:0] LINE_CLOCK_IN,
  input wire logic STARTUP_DELAY_NODE_AT_REF,
  input wire logic NEG_RAIL_DISCHARGE_CTL_BELOW,
  output logic [2*NUM_CH-1:0] GATE_CLOCK_OUT,
  output logic [2*NUM_CH-1:0] GATE_CLOCK_INV_OUT,
  output logic [1:0] FRAME_START_OUT,
  output logic STARTUP_DELAY_CHARGE_EN,
  output logic NEG_RAIL_DISCHARGE_ON
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Every input is a comparator or pin level, so all pass two flops
  // Limitation: a line clock pulse shorter than one clock can be missed
  logic [SYNC_W-1:0] sync1_q, sync1_d;
  logic [SYNC_W-1:0] sync2_q, sync2_d;

  always_comb begin
    sync1_d = {NEG_RAIL_DISCHARGE_CTL_BELOW, STARTUP_DELAY_NODE_AT_REF, LINE_CLOCK_IN,
               FRAME_START_IN, EN, SUPPLY_LOCKOUT_OK};
    sync2_d = sync1_q;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  logic frame_s;
  logic [NUM_CH-1:0] line_s;

  always_comb begin
    frame_s = sync2_q[SYN_FRAME];
    line_s = sync2_q[SYN_LINE0 +: NUM_CH];
  end

  // ****************************************
  // Start-up sequencer
  // ****************************************
  psd_seq_if sq_if ();

  assign sq_if.lockout_ok = sync2_q[SYN_VON_OK];
  assign sq_if.enable = sync2_q[SYN_EN];
  assign sq_if.delay_at_ref = sync2_q[SYN_DLY_REF];

  psd_startup_seq u_seq (
    .clk(CLK),
    .rst(SYS_RST),
    .sq(sq_if.seq)
  );

  // ****************************************
  // Line clock edges and channel phase
  // ****************************************
  // Phase 1 means the true output sits on the high rail
  logic [NUM_CH-1:0] line_prev_q, line_prev_d;
  logic [NUM_CH-1:0] phase_q, phase_d;
  logic [NUM_CH-1:0] line_rise;

  always_comb begin
    line_prev_d = line_s;
    line_rise = line_s & ~line_prev_q;
    phase_d = phase_q;
    for (int i = 0; i < NUM_CH; i++) begin
      if (frame_s) begin
        phase_d[i] = line_s[i];
      end else if (line_rise[i]) begin
        phase_d[i] = ~phase_q[i];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      line_prev_q <= '0;
      phase_q <= '0;
    end else begin
      line_prev_q <= line_prev_d;
      phase_q <= phase_d;
    end
  end

  // ****************************************
  // Output drive selection
  // ****************************************
  function automatic psd_drv_t rail_of(input logic high);
    return high ? DRV_HIGH : DRV_LOW;
  endfunction

  // One drive code on every channel of a gate clock bank
  function automatic logic [2*NUM_CH-1:0] fill_codes(input psd_drv_t code);
    return {NUM_CH{code}};
  endfunction

  logic [2*NUM_CH-1:0] gate_q, gate_d;
  logic [2*NUM_CH-1:0] gate_inv_q, gate_inv_d;
  logic [1:0] frame_out_q, frame_out_d;

  // Mode is decoded first, so the input tables never put a rail on a pin
  // while the supply or the enable is not yet trusted
  always_comb begin
    gate_d = fill_codes(DRV_HIZ);
    gate_inv_d = fill_codes(DRV_HIZ);
    frame_out_d = DRV_HIZ;
    // sequencer mode ranks above the tables
    unique case (sq_if.mode)
      SEQ_LOCKOUT: begin
        gate_d = fill_codes(DRV_HIZ);
        gate_inv_d = fill_codes(DRV_HIZ);
        frame_out_d = DRV_HIZ;
      end
      SEQ_DISABLED, SEQ_DELAY: begin
        gate_d = fill_codes(DRV_LOW);
        gate_inv_d = fill_codes(DRV_LOW);
        frame_out_d = DRV_LOW;
      end
      SEQ_RUN: begin
        if (!frame_s) begin
          frame_out_d = DRV_LOW;
        end else if (!line_s[0]) begin
          frame_out_d = DRV_HIGH;
        end else begin
          frame_out_d = DRV_HIZ;
        end
        for (int i = 0; i < NUM_CH; i++) begin
          if (!frame_s && !line_s[i]) begin
            gate_d[2*i +: 2] = DRV_SHARE;
            gate_inv_d[2*i +: 2] = DRV_SHARE;
          end else begin
            gate_d[2*i +: 2] = rail_of(phase_d[i]);
            gate_inv_d[2*i +: 2] = rail_of(~phase_d[i]);
          end
        end
      end
      default: begin
        // Illegal sequencer code: fall back to the safe floating state
        gate_d = fill_codes(DRV_HIZ);
        gate_inv_d = fill_codes(DRV_HIZ);
        frame_out_d = DRV_HIZ;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      gate_q <= fill_codes(DRV_HIZ);
      gate_inv_q <= fill_codes(DRV_HIZ);
      frame_out_q <= DRV_HIZ;
    end else begin
      gate_q <= gate_d;
      gate_inv_q <= gate_inv_d;
      frame_out_q <= frame_out_d;
    end
  end

  // ****************************************
  // Delay node charge and negative rail discharge
  // ****************************************
  // Discharge ignores the sequencer: it must act while the supplies collapse
  logic charge_q, charge_d;
  logic disch_q, disch_d;

  always_comb begin
    // node charges only while the delay runs
    charge_d = (sq_if.mode == SEQ_DELAY);
    disch_d = sync2_q[SYN_DISCH];
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      charge_q <= 1'b0;
      disch_q <= 1'b0;
    end else begin
      charge_q <= charge_d;
      disch_q <= disch_d;
    end
  end

  assign GATE_CLOCK_OUT = gate_q;
  assign GATE_CLOCK_INV_OUT = gate_inv_q;
  assign FRAME_START_OUT = frame_out_q;
  assign STARTUP_DELAY_CHARGE_EN = charge_q;
  assign NEG_RAIL_DISCHARGE_ON = disch_q;

endmodule

// file: shared/psd_pkg.sv
// Shared constants and types of the panel scan output control
package psd_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  // Node blanking after charge starts, so a stale comparator level is ignored
  localparam int unsigned DLY_BLANK_NS = 40;
  localparam int unsigned DLY_BLANK_CYC =
    ((DLY_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((DLY_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned DLY_CNT_W = 4;

  // ****************************************
  // Widths and sync vector layout
  // ****************************************
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned SYNC_W = 8;
  localparam int unsigned SYN_VON_OK = 0;
  localparam int unsigned SYN_EN = 1;
  localparam int unsigned SYN_FRAME = 2;
  localparam int unsigned SYN_LINE0 = 3;
  localparam int unsigned SYN_DLY_REF = 6;
  localparam int unsigned SYN_DISCH = 7;
  localparam logic [SYNC_W-1:0] SYNC_RST = 8'h00;

  // ****************************************
  // Output drive states
  // ****************************************
  typedef enum logic [1:0] {
    DRV_HIZ = 2'h0,
    DRV_HIGH = 2'h1,
    DRV_LOW = 2'h2,
    DRV_SHARE = 2'h3
  } psd_drv_t;

  // ****************************************
  // Start-up sequencer states
  // ****************************************
  typedef enum logic [3:0] {
    SEQ_LOCKOUT = 4'h1,
    SEQ_DISABLED = 4'h2,
    SEQ_DELAY = 4'h4,
    SEQ_RUN = 4'h8
  } psd_seq_t;

endpackage

// file: shared/psd_seq_if.sv
// Carrier between the output control and its start-up sequencer
`timescale 1ns/1ns
interface psd_seq_if;
  import psd_pkg::*;
  logic lockout_ok;
  logic enable;
  logic delay_at_ref;
  psd_seq_t mode;

  modport ctrl (output lockout_ok, output enable, output delay_at_ref, input mode);
  modport seq (input lockout_ok, input enable, input delay_at_ref, output mode);
endinterface

// file: rtl/psd_startup_seq.sv
// Start-up sequencer: supply lockout, enable and delay-node timing
`timescale 1ns/1ns
module psd_startup_seq
  import psd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  psd_seq_if.seq sq
);

  psd_seq_t state_q, state_d;
  logic [DLY_CNT_W-1:0] blank_q, blank_d;
  logic en_prev_q, en_prev_d;

  always_comb begin
    state_d = state_q;
    blank_d = blank_q;
    en_prev_d = sq.enable;
    if (!sq.lockout_ok) begin
      state_d = SEQ_LOCKOUT;
    end else begin
      unique case (state_q)
        SEQ_LOCKOUT: begin
          state_d = sq.enable ? SEQ_DELAY : SEQ_DISABLED;
        end
        SEQ_DISABLED: begin
          if (sq.enable && !en_prev_q) begin
            state_d = SEQ_DELAY;
          end
        end
        SEQ_DELAY: begin
          if (!sq.enable) begin
            state_d = SEQ_DISABLED;
          end else if (blank_q == '0 && sq.delay_at_ref) begin
            state_d = SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (!sq.enable) begin
            state_d = SEQ_DISABLED;
          end
        end
      endcase
    end
    // Blanking restarts whenever the delay begins
    if (state_d == SEQ_DELAY && state_q != SEQ_DELAY) begin
      blank_d = DLY_CNT_W'(DLY_BLANK_CYC);
    end else if (blank_q != '0) begin
      blank_d = blank_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SEQ_LOCKOUT;
      blank_q <= '0;
      en_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      blank_q <= blank_d;
      en_prev_q <= en_prev_d;
    end
  end

  assign sq.mode = state_q;

endmodule

// file: tb/psd_scan_ctrl_checker.sv
// Checker of the panel scan output control ports
`timescale 1ns/1ns
module psd_scan_ctrl_checker
  import psd_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic SUPPLY_LOCKOUT_OK,
  input wire logic EN,
  input wire logic FRAME_START_IN,
  input wire logic [NUM_CH-1:0] LINE_CLOCK_IN,
  input wire logic STARTUP_DELAY_NODE_AT_REF,
  input wire logic NEG_RAIL_DISCHARGE_CTL_BELOW,
  input wire logic [2*NUM_CH-1:0] GATE_CLOCK_OUT,
  input wire logic [2*NUM_CH-1:0] GATE_CLOCK_INV_OUT,
  input wire logic [1:0] FRAME_START_OUT,
  input wire logic STARTUP_DELAY_CHARGE_EN,
  input wire logic NEG_RAIL_DISCHARGE_ON
);
  // ****************
  // Helpers
  // ****************
  logic [4:0] up_q;
  logic [4:0] up_d;
  logic run;
  logic [13:0] all;
  logic [1:0] g0;
  logic [1:0] i0;
  logic f;
  logic l0;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  assign all = {GATE_CLOCK_OUT, GATE_CLOCK_INV_OUT, FRAME_START_OUT};
  assign g0 = GATE_CLOCK_OUT[1:0];
  assign i0 = GATE_CLOCK_INV_OUT[1:0];
  assign f = FRAME_START_IN;
  assign l0 = LINE_CLOCK_IN[0];
  assign run = up_q == 5'h14;
  // Margin past syncs and blanking before the tables apply
  always_comb begin
    up_d = run ? up_q : up_q + 5'h01;
    if (!(SUPPLY_LOCKOUT_OK && EN && STARTUP_DELAY_NODE_AT_REF)) up_d = 5'h00;
  end
  always_ff @(posedge CLK) begin
    up_q <= SYS_RST ? 5'h00 : up_d;
  end
  // ****************
  // Properties
  // ****************
  property p_lock;
    !SUPPLY_LOCKOUT_OK [*5] |=> all == 14'h0000 && !STARTUP_DELAY_CHARGE_EN;
  endproperty
  a_lock: assert property (p_lock) else $error("not floating in lockout");
  property p_off;
    (SUPPLY_LOCKOUT_OK && !EN) [*6] |=> all == 14'h2aaa;
  endproperty
  a_off: assert property (p_off) else $error("not low when disabled");
  property p_dly;
    (!EN || !SUPPLY_LOCKOUT_OK) [*3] ##1 (SUPPLY_LOCKOUT_OK && EN && !STARTUP_DELAY_NODE_AT_REF) [*6]
      |=> all == 14'h2aaa && STARTUP_DELAY_CHARGE_EN;
  endproperty
  a_dly: assert property (p_dly) else $error("delay not running");
  property p_fhi;
    (run && f && l0) [*4] |=> g0 == DRV_HIGH && i0 == DRV_LOW && FRAME_START_OUT == DRV_HIZ;
  endproperty
  a_fhi: assert property (p_fhi) else $error("frame high, line high");
  property p_flo;
    (run && f && !l0) [*4] |=> g0 == DRV_LOW && i0 == DRV_HIGH && FRAME_START_OUT == DRV_HIGH;
  endproperty
  a_flo: assert property (p_flo) else $error("frame high, line low");
  property p_share;
    (run && !f && !l0) [*4] |=> g0 == DRV_SHARE && i0 == DRV_SHARE && FRAME_START_OUT == DRV_LOW;
  endproperty
  a_share: assert property (p_share) else $error("no share on line low");
  property p_hold;
    (run && !f && l0) [*5] |=> $stable(g0) && g0 == (i0 ^ 2'h3) && g0[0] != g0[1];
  endproperty
  a_hold: assert property (p_hold) else $error("toggled pair not held");
  property p_disch;
    NEG_RAIL_DISCHARGE_CTL_BELOW [*4] |=> NEG_RAIL_DISCHARGE_ON;
  endproperty
  a_disch: assert property (p_disch) else $error("discharge switch open");
endmodule
bind psd_scan_ctrl psd_scan_ctrl_checker chk_u (.CLK, .SYS_RST, .SUPPLY_LOCKOUT_OK, .EN,
  .FRAME_START_IN, .LINE_CLOCK_IN, .STARTUP_DELAY_NODE_AT_REF, .NEG_RAIL_DISCHARGE_CTL_BELOW,
  .GATE_CLOCK_OUT, .GATE_CLOCK_INV_OUT, .FRAME_START_OUT, .STARTUP_DELAY_CHARGE_EN,
  .NEG_RAIL_DISCHARGE_ON);

// file: tb/psd_tcon_model.sv
// Timing controller model: frame start and line clocks
`timescale 1ns/1ns
module psd_tcon_model (
  input wire logic clk,
  output logic frame,
  output logic [2:0] line
);
  initial begin
    frame = 1'b0;
    line = 3'h0;
  end
  // frame start changes level once per frame
  task automatic flip_frame;
    @(posedge clk) frame <= ~frame;
  endtask
  // line clocks change once per line, channels chosen by mask
  task automatic flip_lines(input logic [2:0] mask);
    @(posedge clk) line <= line ^ mask;
  endtask
endmodule

// file: tb/psd_scan_ctrl_test.sv
// Self-checking bench of the panel scan output control
`timescale 1ns/1ns
module psd_scan_ctrl_test;
  import psd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] pin = 4'h0;
  logic frame;
  logic [2:0] line;
  logic [5:0] g;
  logic [5:0] gi;
  logic [1:0] fo;
  logic chg;
  logic dis;
  int n_errors = 0;
  int comparisons = 0;
  always #4 clk = ~clk;
  psd_tcon_model tcon_u (.clk(clk), .frame(frame), .line(line));
  psd_scan_ctrl dut_u (.CLK(clk), .SYS_RST(rst), .SUPPLY_LOCKOUT_OK(pin[3]), .EN(pin[2]),
    .FRAME_START_IN(frame), .LINE_CLOCK_IN(line), .STARTUP_DELAY_NODE_AT_REF(pin[1]),
    .NEG_RAIL_DISCHARGE_CTL_BELOW(pin[0]), .GATE_CLOCK_OUT(g), .GATE_CLOCK_INV_OUT(gi),
    .FRAME_START_OUT(fo), .STARTUP_DELAY_CHARGE_EN(chg), .NEG_RAIL_DISCHARGE_ON(dis));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string name, input logic [5:0] exp, input logic [5:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Pins: lockout ok, enable, node at reference, discharge below
  task automatic pins(input logic [3:0] v, input int n);
    @(posedge clk) pin <= v;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic outs(input logic [5:0] eg, input logic [5:0] ei, input logic [1:0] ef);
    chk("true", eg, g);
    chk("inv", ei, gi);
    chk("frame", {4'h0, ef}, {4'h0, fo});
  endtask
  task automatic t_startup;
    pins(4'b0100, 6);
    outs(6'h00, 6'h00, 2'h0);
    pins(4'b1100, 8);
    outs(6'h2a, 6'h2a, 2'h2);
    chk("charge", 6'h01, {5'h00, chg});
    pins(4'b1110, 16);
  endtask
  task automatic t_frame_high;
    tcon_u.flip_frame();
    tcon_u.flip_lines(3'h7);
    pins(4'b1110, 6);
    outs(6'h15, 6'h2a, 2'h0);
    tcon_u.flip_lines(3'h7);
    pins(4'b1110, 6);
    outs(6'h2a, 6'h15, 2'h1);
  endtask
  // Phase left low by frame high and line low, so the first rise drives high
  task automatic t_frame_low;
    tcon_u.flip_frame();
    pins(4'b1110, 6);
    outs(6'h3f, 6'h3f, 2'h2);
    tcon_u.flip_lines(3'h7);
    pins(4'b1110, 6);
    chk("inv", 6'h2a, gi);
    pins(4'b1110, 6);
    chk("hold", 6'h15, g);
    tcon_u.flip_lines(3'h7);
    pins(4'b1110, 6);
    outs(6'h3f, 6'h3f, 2'h2);
    tcon_u.flip_lines(3'h7);
    pins(4'b1110, 6);
    outs(6'h2a, 6'h15, 2'h2);
    tcon_u.flip_lines(3'h5);
    pins(4'b1110, 6);
    outs(6'h3b, 6'h37, 2'h2);
    tcon_u.flip_lines(3'h2);
  endtask
  task automatic t_disable;
    pins(4'b1000, 6);
    outs(6'h2a, 6'h2a, 2'h2);
    pins(4'b1100, 8);
    outs(6'h2a, 6'h2a, 2'h2);
    chk("charge", 6'h01, {5'h00, chg});
    pins(4'b1110, 16);
    outs(6'h3f, 6'h3f, 2'h2);
  endtask
  task automatic t_discharge;
    pins(4'b1111, 5);
    chk("disch", 6'h01, {5'h00, dis});
    pins(4'b1110, 5);
    chk("disch", 6'h00, {5'h00, dis});
    pins(4'b0110, 6);
    outs(6'h00, 6'h00, 2'h0);
    // Floating node: only the blanking stands between threshold and run
    pins(4'b1110, 14);
    outs(6'h3f, 6'h3f, 2'h2);
  endtask
  task automatic finish_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_startup();
    t_frame_high();
    t_frame_low();
    t_disable();
    t_discharge();
    finish_test();
  end
  // Run takes about 175 cycles
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    finish_test();
  end
endmodule
